// file: core/twss_defines.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * tape write step sequencer.
 * Assumes a 10 MHz system clock and a 32-bit APB register bus.
 */
`ifndef TWSS_DEFINES_SVH
`define TWSS_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TWSS_ORDER_OFS    12'h000
`define TWSS_STATUS_OFS   12'h004
`define TWSS_ADDR_OFS     12'h008
`define TWSS_DATA_OFS     12'h00C
`define TWSS_COUNT_OFS    12'h010

// ----------------------------------------
// order register fields
// ----------------------------------------
`define TWSS_ORD_CODE_HI  2
`define TWSS_ORD_UNIT_LO  4
`define TWSS_ORD_UNIT_HI  5

// ----------------------------------------
// status register bit positions
// ----------------------------------------
`define TWSS_ST_SELDONE   0
`define TWSS_ST_RWTEN     1
`define TWSS_ST_CHKTEN    2
`define TWSS_ST_UCAVAIL   3
`define TWSS_ST_UNAVAIL   4
`define TWSS_ST_RWAVAIL   5
`define TWSS_ST_CHKAVAIL  6
`define TWSS_ST_RDAVAIL   7
`define TWSS_ST_MOVING    8
`define TWSS_ST_UNIT_LO   12

// ----------------------------------------
// sizes and reset values
// ----------------------------------------
`define TWSS_UNITS        4
`define TWSS_GROUP_WORDS  4'h9
`define TWSS_FIFO_DEPTH   8
`define TWSS_ADDR_RST     32'h00000000

// ----------------------------------------
// timing, clock rate and intervals
// ----------------------------------------
`define TWSS_CLK_MHZ      10
`define TWSS_ACCEL_US     3000
`define TWSS_GAP_US       2500
`define TWSS_WORD_US      20
`define TWSS_WORD_CYC     (`TWSS_WORD_US * `TWSS_CLK_MHZ)
`define TWSS_TMR_W        20

`endif

// file: core/twss_fifo.sv
/*
 * Word buffer between the register bus and the write circuits.
 * Assumes one clock domain; push and pop use valid/ready handshakes.
 */
`timescale 1ns/100ps

module twss_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wrPtr_reg;
	logic [AW-1:0]    rdPtr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	// honest full and empty from the fill count
	assign inReady  = (count_reg != (AW+1)'(DEPTH));
	assign outValid = (count_reg != '0);
	assign outData  = mem_reg[rdPtr_reg];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// storage, written by index
	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wrPtr_reg] <= inData;
	end

	// pointers and fill count
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
			if (pop)
				rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
			if (push && !pop)
				count_reg <= count_reg + 1'b1;
			else if (pop && !push)
				count_reg <= count_reg - 1'b1;
		end
	end

endmodule : twss_fifo

// file: core/twss_pkg.sv
/*
 * Types of the tape write step sequencer: order codes and states.
 * Assumes twss_defines.svh is reachable on the include path.
 */
package twss_pkg;

	// order codes written to the order register
	typedef enum logic [2:0] {
		TWSS_NOP      = 3'h0,
		TWSS_SELECT   = 3'h1,
		TWSS_PREPARE  = 3'h2,
		TWSS_MOVE     = 3'h3,
		TWSS_WRITE    = 3'h4,
		TWSS_CONTINUE = 3'h5,
		TWSS_GAPCONT  = 3'h6,
		TWSS_CHKACK   = 3'h7
	} twss_order_t;

	// unit control section states
	typedef enum logic [1:0] {UC_IDLE, UC_PREP, UC_MOVING} twss_uc_t;

	// read-write control section states
	typedef enum logic [1:0] {RW_IDLE, RW_WAIT, RW_WORDS, RW_GAP} twss_rw_t;

endpackage : twss_pkg

// file: core/twss_timer.sv
/*
 * One-shot interval timer: load starts a count, done pulses at its end.
 * Assumes load is a one-cycle pulse from the same clock domain.
 */
`timescale 1ns/100ps
`include "twss_defines.svh"

module twss_timer (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   load,
	input  wire logic [`TWSS_TMR_W-1:0] cycles,
	output logic                        busy,
	output logic                        done
);
	logic [`TWSS_TMR_W-1:0] cnt_reg;

	// a new load restarts the full interval, like a retriggered delay
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_reg <= '0;
			done    <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (load)
				cnt_reg <= cycles;
			else if (cnt_reg != '0)
			begin
				cnt_reg <= cnt_reg - 1'b1;
				done    <= (cnt_reg == `TWSS_TMR_W'(1));
			end
		end
	end

	assign busy = (cnt_reg != '0);

endmodule : twss_timer

// file: core/twss_top.sv
/*
 * Tape write step sequencer: unit control section, read-write control
 * with its word buffer, completion flags and availability status, all
 * reached over APB.
 * Assumes the program polls the status word and orders one step at a
 * time; tape unit pins are asynchronous and pass two flip-flops.
 */
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`include "twss_defines.svh"

// How it works
// - finishing an ordered task sets a flag that the program's priority poll sees.
// - the unit control section owns a selection-completed flag set when its task ends.
// - the read-write control and the positioning checker each own a separate ten-word flag.
// - status shows availability of unit control, the selected unit, read-write, checker and read.
// - a select order selects the given unit and then sets the selection-completed flag.
// - a prepare order drives the forward and write relays and flags once they pulled in.
// - the ten-word flag is set when writing starts and again at each new group of ten.
// - each alert is answered with continue or gap-then-continue, applied at the group end.
// - acceleration and gap intervals that block writing are timed here without the program.
// - after an order the block runs alone and alerts only when it needs the next order.
module twss_top
	import twss_pkg::*;
#(
	parameter int ACCEL_CYC = `TWSS_ACCEL_US * `TWSS_CLK_MHZ,
	parameter int GAP_CYC   = `TWSS_GAP_US * `TWSS_CLK_MHZ
) (
	input  wire logic                    clk,
	input  wire logic                    nrst,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic [`TWSS_UNITS-1:0]  unitInterlock,
	input  wire logic [`TWSS_UNITS-1:0]  unitBusy,
	input  wire logic                    relayPulledIn,
	input  wire logic                    checkerBusy,
	input  wire logic                    checkerTen,
	input  wire logic                    readBusy,
	output logic      [`TWSS_UNITS-1:0]  unitSelect,
	output logic                         forwardRelay,
	output logic                         writeRelay,
	output logic                         tapeMove,
	output logic      [31:0]             headData,
	output logic                         headStrobe,
	output logic      [31:0]             memAddr
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	localparam int SW = 2 * `TWSS_UNITS + 4;

	logic [SW-1:0] pinMeta_reg;
	logic [SW-1:0] pinSync_reg;
	logic          chkTenLast_reg;

	// two flops before any logic; only the second stage is read
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end
		else
		begin
			pinMeta_reg <= {unitInterlock, unitBusy, relayPulledIn, checkerBusy,
				checkerTen, readBusy};
			pinSync_reg <= pinMeta_reg;
		end
	end

	logic [`TWSS_UNITS-1:0] interlockS;
	logic [`TWSS_UNITS-1:0] unitBusyS;
	logic                   pulledInS;
	logic                   chkBusyS;
	logic                   chkTenS;
	logic                   readBusyS;

	assign {interlockS, unitBusyS, pulledInS, chkBusyS, chkTenS, readBusyS} = pinSync_reg;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	logic        access;
	logic        wrTake;
	logic        rdTake;
	logic        isOrder;
	logic        isData;
	logic        isAddr;
	logic        fifoInReady;
	twss_order_t order;
	logic [1:0]  orderUnit;

	assign access    = psel & penable;
	assign wrTake    = access & pready & pwrite;
	assign rdTake    = access & pready & ~pwrite;
	assign isOrder   = (paddr == `TWSS_ORDER_OFS);
	assign isData    = (paddr == `TWSS_DATA_OFS);
	assign isAddr    = (paddr == `TWSS_ADDR_OFS);
	assign order     = twss_order_t'(pwdata[`TWSS_ORD_CODE_HI:0]);
	assign orderUnit = pwdata[`TWSS_ORD_UNIT_HI:`TWSS_ORD_UNIT_LO];

	logic ordSelect;
	logic ordPrepare;
	logic ordMove;
	logic ordWrite;
	logic ordCont;
	logic ordGap;
	logic ordChkAck;

	// one-cycle order strobes, taken at the completing edge
	assign ordSelect  = wrTake & isOrder & (order == TWSS_SELECT);
	assign ordPrepare = wrTake & isOrder & (order == TWSS_PREPARE);
	assign ordMove    = wrTake & isOrder & (order == TWSS_MOVE);
	assign ordWrite   = wrTake & isOrder & (order == TWSS_WRITE);
	assign ordCont    = wrTake & isOrder & (order == TWSS_CONTINUE);
	assign ordGap     = wrTake & isOrder & (order == TWSS_GAPCONT);
	assign ordChkAck  = wrTake & isOrder & (order == TWSS_CHKACK);

	logic [31:0] status;
	logic [31:0] readMux;
	logic [3:0]  wordCnt_reg;
	logic        known;

	// address decode for reads; unmapped offsets answer with an error
	always_comb
	begin
		readMux = 32'h00000000;
		known   = 1'b1;
		if (isOrder)
			readMux = 32'h00000000;
		else if (paddr == `TWSS_STATUS_OFS)
			readMux = status;
		else if (isAddr)
			readMux = memAddr;
		else if (isData)
			readMux = 32'h00000000;
		else if (paddr == `TWSS_COUNT_OFS)
			readMux = {28'h0000000, wordCnt_reg};
		else
			known = 1'b0;
	end

	// one wait state; a data write also waits while the buffer is full
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= access & ~pready & ~(pwrite & isData & ~fifoInReady);
			pslverr <= access & ~pready & ~known;
			prdata  <= (access & ~pready & ~pwrite) ? readMux : 32'h00000000;
		end
	end

	// start address register, advanced per word written
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			memAddr <= `TWSS_ADDR_RST;
		else if (wrTake && isAddr)
			memAddr <= pwdata;
		else if (headStrobe)
			memAddr <= memAddr + 32'h00000001;
	end

	// ----------------------------------------
	// unit control section
	// ----------------------------------------
	twss_uc_t ucState_reg;
	logic     selDone_reg;
	logic     selDoneSet;
	logic     ucSetDone;
	logic     accelLoad;
	logic     accelBusy;
	logic     accelDone;
	logic     accelOk_reg;
	logic     rwEnd;
	logic [1:0] unitIdx_reg;

	// select acts at once; prepare waits for the relay contacts
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ucState_reg  <= UC_IDLE;
			unitIdx_reg  <= 2'h0;
			unitSelect   <= '0;
			forwardRelay <= 1'b0;
			writeRelay   <= 1'b0;
			tapeMove     <= 1'b0;
		end
		else
		begin
			case (ucState_reg)
				UC_IDLE:
				begin
					if (ordSelect)
					begin
						unitIdx_reg <= orderUnit;
						unitSelect  <= `TWSS_UNITS'(1) << orderUnit;
					end
					else if (ordPrepare)
					begin
						forwardRelay <= 1'b1;
						writeRelay   <= 1'b1;
						ucState_reg  <= UC_PREP;
					end
					else if (ordMove && writeRelay)
					begin
						tapeMove    <= 1'b1;
						ucState_reg <= UC_MOVING;
					end
				end
				UC_PREP:
				begin
					if (pulledInS)
						ucState_reg <= UC_IDLE;
				end
				UC_MOVING:
				begin
					// motion stops only after the last word has reached the head
					if (rwEnd)
					begin
						tapeMove     <= 1'b0;
						forwardRelay <= 1'b0;
						writeRelay   <= 1'b0;
						ucState_reg  <= UC_IDLE;
					end
				end
				default:
					ucState_reg <= UC_IDLE;
			endcase
		end
	end

	// completion of select, or of relay pull-in
	assign ucSetDone = (ucState_reg == UC_IDLE && ordSelect)
		| (ucState_reg == UC_PREP && pulledInS);
	assign accelLoad = ucState_reg == UC_IDLE && ordMove && writeRelay;

	// selection-completed flag: set wins over the clearing order
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			selDone_reg <= 1'b0;
		else if (selDoneSet)
			selDone_reg <= 1'b1;
		else if (ordSelect || ordPrepare || ordMove)
			selDone_reg <= 1'b0;
	end

	assign selDoneSet = ucSetDone;

	// acceleration interval blocks writing without program help
	twss_timer accelTimer (
		.clk    (clk),
		.nrst   (nrst),
		.load   (accelLoad),
		.cycles (`TWSS_TMR_W'(ACCEL_CYC)),
		.busy   (accelBusy),
		.done   (accelDone)
	);

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			accelOk_reg <= 1'b0;
		else if (accelLoad || !tapeMove)
			accelOk_reg <= 1'b0;
		else if (accelDone)
			accelOk_reg <= 1'b1;
	end

	// ----------------------------------------
	// read-write control and write circuits
	// ----------------------------------------
	typedef enum logic [1:0] {CH_NONE, CH_CONT, CH_GAP} twss_choice_t;

	twss_rw_t     rwState_reg;
	twss_choice_t choice_reg;
	logic         rwTen_reg;
	logic         rwTenSet;
	logic [7:0]   pace_reg;
	logic         fifoOutValid;
	logic [31:0]  fifoOutData;
	logic         pop;
	logic         gapLoad;
	logic         gapBusy;
	logic         gapDone;

	// a word leaves the buffer every word time while writing
	assign pop     = (rwState_reg == RW_WORDS) && (pace_reg == 8'h00) && fifoOutValid;
	assign gapLoad = pop && (wordCnt_reg == `TWSS_GROUP_WORDS) && (choice_reg == CH_GAP);
	assign rwEnd   = headStrobe && (rwState_reg == RW_IDLE); // strobe of the closing word

	// ten-word flag on first word and on each new group
	assign rwTenSet = (rwState_reg == RW_WAIT && accelOk_reg)
		| (pop && wordCnt_reg == `TWSS_GROUP_WORDS && choice_reg == CH_CONT)
		| gapDone;

	// group sequencing; the choice is applied at the end of the group
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rwState_reg <= RW_IDLE;
			choice_reg  <= CH_NONE;
			wordCnt_reg <= 4'h0;
		end
		else
		begin
			case (rwState_reg)
				RW_IDLE:
				begin
					wordCnt_reg <= 4'h0;
					choice_reg  <= CH_NONE;
					if (ordWrite && tapeMove)
						rwState_reg <= RW_WAIT;
				end
				RW_WAIT:
				begin
					if (accelOk_reg)
						rwState_reg <= RW_WORDS;
				end
				RW_WORDS:
				begin
					if (ordCont)
						choice_reg <= CH_CONT;
					else if (ordGap)
						choice_reg <= CH_GAP;
					if (pop)
					begin
						if (wordCnt_reg != `TWSS_GROUP_WORDS)
							wordCnt_reg <= wordCnt_reg + 4'h1;
						else
						begin
							wordCnt_reg <= 4'h0;
							choice_reg  <= CH_NONE;
							if (choice_reg == CH_GAP)
								rwState_reg <= RW_GAP;
							else if (choice_reg == CH_NONE)
								rwState_reg <= RW_IDLE;
						end
					end
				end
				RW_GAP:
				begin
					if (gapDone)
						rwState_reg <= RW_WORDS;
				end
				default:
					rwState_reg <= RW_IDLE;
			endcase
		end
	end

	// word pacing and head drive
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pace_reg   <= 8'h00;
			headStrobe <= 1'b0;
			headData   <= 32'h00000000;
		end
		else
		begin
			headStrobe <= pop;
			if (pop)
			begin
				headData <= fifoOutData;
				pace_reg <= 8'(`TWSS_WORD_CYC - 1);
			end
			else if (pace_reg != 8'h00)
				pace_reg <= pace_reg - 8'h01;
		end
	end

	// ten-word flag of the read-write control; set wins over clear
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			rwTen_reg <= 1'b0;
		else if (rwTenSet)
			rwTen_reg <= 1'b1;
		else if (ordWrite || ordCont || ordGap)
			rwTen_reg <= 1'b0;
	end

	// inter-block gap interval
	twss_timer gapTimer (
		.clk    (clk),
		.nrst   (nrst),
		.load   (gapLoad),
		.cycles (`TWSS_TMR_W'(GAP_CYC)),
		.busy   (gapBusy),
		.done   (gapDone)
	);

	// buffer stalls the bus while full, so it really fills
	twss_fifo #(
		.WIDTH (32),
		.DEPTH (`TWSS_FIFO_DEPTH)
	) wordFifo (
		.clk      (clk),
		.nrst     (nrst),
		.inValid  (wrTake & isData),
		.inReady  (fifoInReady),
		.inData   (pwdata),
		.outValid (fifoOutValid),
		.outReady (pop),
		.outData  (fifoOutData)
	);

	// ----------------------------------------
	// positioning checker flag and status
	// ----------------------------------------
	logic chkTen_reg;
	logic chkRise;

	assign chkRise = chkTenS & ~chkTenLast_reg;

	// checker's own ten-word flag, from its edge; set wins over clear
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			chkTenLast_reg <= 1'b0;
			chkTen_reg     <= 1'b0;
		end
		else
		begin
			chkTenLast_reg <= chkTenS;
			if (chkRise)
				chkTen_reg <= 1'b1;
			else if (ordChkAck)
				chkTen_reg <= 1'b0;
		end
	end

	// availability indications; write circuits need none
	always_comb
	begin
		status                    = 32'h00000000;
		status[`TWSS_ST_SELDONE]  = selDone_reg;
		status[`TWSS_ST_RWTEN]    = rwTen_reg;
		status[`TWSS_ST_CHKTEN]   = chkTen_reg;
		status[`TWSS_ST_UCAVAIL]  = (ucState_reg == UC_IDLE) & ~tapeMove;
		status[`TWSS_ST_UNAVAIL]  = ~interlockS[unitIdx_reg] & ~unitBusyS[unitIdx_reg];
		status[`TWSS_ST_RWAVAIL]  = (rwState_reg == RW_IDLE);
		status[`TWSS_ST_CHKAVAIL] = ~chkBusyS;
		status[`TWSS_ST_RDAVAIL]  = ~readBusyS;
		status[`TWSS_ST_MOVING]   = tapeMove & ~accelBusy & ~gapBusy;
		status[`TWSS_ST_UNIT_LO +: 2] = unitIdx_reg;
	end

endmodule : twss_top

// file: tb/testbench.sv
/* self-checking bench for the tape write step sequencer
   assumes design, checker and tape model are compiled first */
`timescale 1ns/100ps
`include "twss_defines.svh"
module testbench
	import twss_pkg::*;
;
	localparam int GAP = 500;
	logic        clk, nrst, psel, penable, pwrite, pready, pslverr, e, ckLevel;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, st, r, headData, memAddr, lastWord;
	logic [3:0]  busyMask, unitBusy, unitSelect;
	logic        relayPulledIn, checkerTen, forwardRelay, writeRelay, tapeMove, headStrobe;
	logic [7:0]  words;
	logic [15:0] minGap, maxGap;
	int          fails, num_checks, k, n;

	twss_top #(.ACCEL_CYC(400), .GAP_CYC(GAP)) u_twss_top (.clk(clk), .nrst(nrst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .unitInterlock(4'h0),
		.unitBusy(unitBusy), .relayPulledIn(relayPulledIn), .checkerBusy(ckLevel),
		.checkerTen(checkerTen), .readBusy(ckLevel), .unitSelect(unitSelect),
		.forwardRelay(forwardRelay), .writeRelay(writeRelay), .tapeMove(tapeMove),
		.headData(headData), .headStrobe(headStrobe), .memAddr(memAddr));
	twss_tape_model u_twss_tape_model (.clk(clk), .nrst(nrst), .busyMask(busyMask),
		.ckLevel(ckLevel), .forwardRelay(forwardRelay), .writeRelay(writeRelay),
		.headData(headData), .headStrobe(headStrobe), .unitBusy(unitBusy),
		.relayPulledIn(relayPulledIn), .checkerTen(checkerTen), .words(words),
		.lastWord(lastWord), .minGap(minGap), .maxGap(maxGap));

	// ------
	// tasks
	// ------
	// one apb transfer; waits on pready, then one idle cycle
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		n = 0;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 5000);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 5000)
			fails++;
		@(posedge clk);
	endtask : bus
	task automatic rd();
		bus(1'b0, `TWSS_STATUS_OFS, 32'h0);
		st = r;
	endtask : rd
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x)
		begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk
	// status poll, bounded so a lost flag cannot hang
	task automatic poll(input int b);
		k = 0;
		do
		begin
			rd();
			k++;
		end
		while (st[b] !== 1'b1 && k < 3000);
		chk({31'h0, st[b]}, 32'h1);
	endtask : poll
	task automatic conclude();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	// ------
	// stimulus
	// ------
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard, well past the roughly seven thousand cycles the run needs
	initial
	begin
		repeat (60000) @(posedge clk);
		fails++;
		conclude();
	end
	initial
	begin
		{nrst, psel, penable, pwrite, paddr, pwdata, busyMask, ckLevel} = '0;
		fails = 0;
		num_checks = 0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd();
		chk(st & 32'h000000EF, 32'h000000E8);
		bus(1'b0, 12'h014, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("test 1 done");
		bus(1'b1, `TWSS_ORDER_OFS, 32'h20 | 32'(TWSS_SELECT));
		poll(0);
		chk({28'h0, unitSelect}, 32'h4);
		chk({30'h0, st[13:12]}, 32'h2);
		busyMask <= 4'h4;
		repeat (4) @(posedge clk);
		rd();
		chk({31'h0, st[4]}, 32'h0);
		busyMask <= 4'h0;
		bus(1'b1, `TWSS_ADDR_OFS, 32'h100);
		bus(1'b0, `TWSS_ADDR_OFS, 32'h0);
		chk(r, 32'h100);
		$display("test 2 done");
		bus(1'b1, `TWSS_ORDER_OFS, 32'(TWSS_PREPARE));
		rd();
		chk({31'h0, st[0]}, 32'h0);
		chk({30'h0, forwardRelay, writeRelay}, 32'h3);
		poll(0);
		for (int i = 1; i <= 8; i++)
			bus(1'b1, `TWSS_DATA_OFS, 32'hA0000000 + i);
		repeat (8) @(posedge clk);
		bus(1'b1, `TWSS_ORDER_OFS, 32'(TWSS_MOVE));
		rd();
		chk({30'h0, tapeMove, st[8]}, 32'h2);
		$display("test 3 done");
		bus(1'b1, `TWSS_ORDER_OFS, 32'(TWSS_WRITE));
		poll(1);
		bus(1'b1, `TWSS_ORDER_OFS, 32'(TWSS_CONTINUE));
		// pushes past eight words stall until the head drains one
		for (int i = 9; i <= 20; i++)
			bus(1'b1, `TWSS_DATA_OFS, 32'hA0000000 + i);
		poll(1);
		bus(1'b1, `TWSS_ORDER_OFS, 32'(TWSS_GAPCONT));
		for (int i = 21; i <= 30; i++)
			bus(1'b1, `TWSS_DATA_OFS, 32'hA0000000 + i);
		poll(1);
		n = 0;
		while ((tapeMove !== 1'b0 || words != 8'h1E) && n < 5000)
		begin
			@(posedge clk);
			n++;
		end
		chk({24'h0, words}, 32'h1E);
		chk(lastWord, 32'hA000001E);
		chk(memAddr, 32'h11E);
		chk({16'h0, minGap}, 32'hC8);
		chk({31'h0, maxGap >= 16'(GAP)}, 32'h1);
		chk({30'h0, tapeMove, writeRelay}, 32'h0);
		$display("test 4 done");
		ckLevel <= 1'b1;
		repeat (4) @(posedge clk);
		rd();
		chk({31'h0, st[2]}, 32'h1);
		chk({30'h0, st[7:6]}, 32'h0);
		bus(1'b1, `TWSS_ORDER_OFS, 32'(TWSS_CHKACK));
		ckLevel <= 1'b0;
		rd();
		chk({31'h0, st[2]}, 32'h0);
		$display("test 5 done");
		conclude();
	end
endmodule : testbench

// file: tb/twss_asserts.sv
/* port checker for twss_top, bound to every instance
   assumes a 10 MHz clk and an active-low async nrst */
`timescale 1ns/100ps
`include "twss_defines.svh"
module twss_asserts
	import twss_pkg::*;
#(
	parameter int ACCEL_CYC = 30000,
	parameter int GAP_CYC   = 25000
) (
	input wire logic                   clk,
	input wire logic                   nrst,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [11:0]            paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic [`TWSS_UNITS-1:0] unitSelect,
	input wire logic                   forwardRelay,
	input wire logic                   writeRelay,
	input wire logic                   tapeMove,
	input wire logic                   headStrobe
);
	logic        ordDone;
	logic [1:0]  ordUnit;
	logic [19:0] accCnt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// ------
	// helpers
	// ------
	// order write completing now
	assign ordDone = psel && penable && pready && pwrite && paddr == `TWSS_ORDER_OFS;
	// unit of the last order; accesses are three cycles apart at least
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			ordUnit <= 2'h0;
		else if (ordDone)
			ordUnit <= pwdata[5:4];
	end
	// cycles of motion, saturating so long runs stay quiet
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst || !tapeMove)
			accCnt <= 20'h00000;
		else if (accCnt != 20'hFFFFF)
			accCnt <= accCnt + 20'h00001;
	end

	// ------
	// checks
	// ------
	a_sel_onehot: assert property ($onehot0(unitSelect))
		else $error("more than one unit selected");
	a_select_unit: assert property (ordDone && pwdata[2:0] == TWSS_SELECT && !tapeMove
		&& !forwardRelay |-> ##[1:2] unitSelect[ordUnit]) else $error("unit not selected");
	a_prep_relays: assert property (ordDone && pwdata[2:0] == TWSS_PREPARE && !tapeMove
		&& |unitSelect |-> ##[1:2] forwardRelay && writeRelay) else $error("relays idle");
	a_move_relay: assert property ($rose(tapeMove) |-> writeRelay && forwardRelay)
		else $error("tape moved unprepared");
	a_strobe_move: assert property (headStrobe |-> tapeMove)
		else $error("word written without motion");
	a_accel_wait: assert property (headStrobe |-> accCnt >= ACCEL_CYC - 1)
		else $error("word written during acceleration");
	a_word_space: assert property (headStrobe |=> !headStrobe [*8])
		else $error("words too close");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_unmap: assert property (psel && penable && pready && paddr > 12'h010 |-> pslverr)
		else $error("unmapped access not refused");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h00000000)
		else $error("read data outside access");
endmodule : twss_asserts

bind twss_top twss_asserts #(.ACCEL_CYC(ACCEL_CYC), .GAP_CYC(GAP_CYC)) u_twss_asserts (
	.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.unitSelect(unitSelect), .forwardRelay(forwardRelay), .writeRelay(writeRelay),
	.tapeMove(tapeMove), .headStrobe(headStrobe));

// file: tb/twss_tape_model.sv
/* tape unit stand-in: relay pull-in and head word capture
   assumes relays and head strobe come from the clk domain */
`timescale 1ns/100ps
module twss_tape_model #(
	parameter int PULL = 20
) (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [3:0]  busyMask,
	input  wire logic        ckLevel,
	input  wire logic        forwardRelay,
	input  wire logic        writeRelay,
	input  wire logic [31:0] headData,
	input  wire logic        headStrobe,
	output logic      [3:0]  unitBusy,
	output logic             relayPulledIn,
	output logic             checkerTen,
	output logic      [7:0]  words,
	output logic      [31:0] lastWord,
	output logic      [15:0] minGap,
	output logic      [15:0] maxGap
);
	logic [7:0]  pullCnt;
	logic [15:0] gapCnt;

	// ------
	// unit pins
	// ------
	assign unitBusy      = busyMask;
	assign checkerTen    = ckLevel;
	assign relayPulledIn = pullCnt == 8'(PULL);
	// coils take a while to pull in; drop at once when released
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst || !(forwardRelay && writeRelay))
			pullCnt <= 8'h00;
		else if (pullCnt != 8'(PULL))
			pullCnt <= pullCnt + 8'h01;
	end
	// head side: words and spacing between strobes
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			words    <= 8'h00;
			lastWord <= 32'h00000000;
			gapCnt   <= 16'h0000;
			minGap   <= 16'hFFFF;
			maxGap   <= 16'h0000;
		end
		else
		begin
			gapCnt <= gapCnt + 16'h0001;
			if (headStrobe)
			begin
				words    <= words + 8'h01;
				lastWord <= headData;
				gapCnt   <= 16'h0001;
				if (words != 8'h00 && gapCnt < minGap)
					minGap <= gapCnt;
				if (words != 8'h00 && gapCnt > maxGap)
					maxGap <= gapCnt;
			end
		end
	end
endmodule : twss_tape_model
